// file: src/lvpw_ctl.sv
// Low-voltage protection, reset cause and periodic wakeup control block
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module lvpw_ctl
    import lvpw_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic [DATA_W-1:0]     reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [DATA_W-1:0]     reg_rdata,
    input  wire logic                  por_det_raw,
    input  wire logic                  lvd_det_raw,
    input  wire logic                  lvw_det_raw,
    input  wire logic                  int_clk_1k,
    input  wire logic                  ext_osc_clk,
    input  wire logic                  wake_pin,
    input  wire logic                  other_reset,
    input  wire logic                  stop_req,
    input  wire logic [1:0]            stop_mode_req,
    output logic                       stop_refused,
    output logic                       light_stop,
    output logic                       deep_stop,
    output logic                       detector_active,
    output logic                       detect_trip_high,
    output logic                       warning_trip_high,
    output logic                       sys_reset_out,
    output logic                       irq
);

    // ********************************************************************
    // Input synchronisers
    // ********************************************************************
    localparam int SYNC_W = 6;

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [1:0]        clk_prev_q;
    logic              por_s;
    logic              lvd_s;
    logic              lvw_s;
    logic              wake_s;
    logic              int_tick;
    logic              ext_tick;

    // Two stages for every pin-level input, plus edge history of clocks
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            clk_prev_q <= '0;
        end else if (clk_en) begin
            sync1_q    <= {wake_pin, ext_osc_clk, int_clk_1k,
                           lvw_det_raw, lvd_det_raw, por_det_raw};
            sync2_q    <= sync1_q;
            clk_prev_q <= sync2_q[4:3];
        end
    end

    // Synchronised levels and clock-edge ticks
    assign por_s    = sync2_q[0];
    assign lvd_s    = sync2_q[1];
    assign lvw_s    = sync2_q[2];
    assign int_tick = sync2_q[3] & ~clk_prev_q[0];
    assign ext_tick = sync2_q[4] & ~clk_prev_q[1];
    assign wake_s   = sync2_q[5];

    // ********************************************************************
    // Control and status registers
    // ********************************************************************
    logic             det_en_q,   det_en_d;
    logic             stop_en_q,  stop_en_d;
    logic             rst_en_q,   rst_en_d;
    logic             det_ie_q,   det_ie_d;
    logic             det_flag_q, det_flag_d;
    logic             det_trip_q, det_trip_d;
    logic             wrn_trip_q, wrn_trip_d;
    logic             warn_q,     warn_d;
    logic             por_c_q,    por_c_d;
    logic             lvd_c_q,    lvd_c_d;
    logic             clksel_q,   clksel_d;
    logic             per_ie_q,   per_ie_d;
    logic             per_flag_q, per_flag_d;
    logic [2:0]       period_q,   period_d;
    logic [1:0]       irq_st_q,   irq_st_d;
    logic [1:0]       irq_en_q,   irq_en_d;
    logic [7:0]       rdata_q,    rdata_d;
    logic             hold_q,     hold_d;
    lvpw_state_t      state_q,    state_d;
    logic             refused_q,  refused_d;
    logic             in_stop;
    logic             in_deep;
    logic             det_on;
    logic             det_event;
    logic             lvd_trip;
    logic             per_tick;
    logic             per_expire;
    logic             wr_a;
    logic             wr_c;
    logic             wr_p;
    logic             rst_all;

    // Power-on detection resets the control and status registers and the timer, not the stop state
    assign rst_all   = reset | por_s;
    assign in_stop   = (state_q != ST_RUN);
    assign in_deep   = (state_q == ST_STOP1) | (state_q == ST_STOP2);
    assign det_on    = det_en_q & (~in_stop | stop_en_q);
    assign lvd_trip  = det_on & rst_en_q & lvd_s;
    assign det_event = det_on & det_ie_q & ~rst_en_q & lvd_s;
    assign wr_a      = reg_wr & (reg_addr == OFS_PWR_CTL_A);
    assign wr_c      = reg_wr & (reg_addr == OFS_PWR_CTL_C);
    assign wr_p      = reg_wr & (reg_addr == OFS_PERIODIC_CTL);

    // Next values for registers; hardware sets win over software clears
    always_comb begin
        det_en_d   = det_en_q;
        stop_en_d  = stop_en_q;
        rst_en_d   = rst_en_q;
        det_ie_d   = det_ie_q;
        det_trip_d = det_trip_q;
        wrn_trip_d = wrn_trip_q;
        clksel_d   = clksel_q;
        per_ie_d   = per_ie_q;
        period_d   = period_q;
        irq_en_d   = irq_en_q;
        det_flag_d = det_flag_q;
        warn_d     = warn_q;
        per_flag_d = per_flag_q;
        irq_st_d   = irq_st_q;
        por_c_d    = por_c_q;
        lvd_c_d    = lvd_c_q;
        if (wr_a) begin
            det_en_d  = reg_wdata[A_DET_EN_BIT];
            stop_en_d = reg_wdata[A_STOP_EN_BIT];
            rst_en_d  = reg_wdata[A_RST_EN_BIT];
            det_ie_d  = reg_wdata[A_IRQ_EN_BIT];
            if (reg_wdata[A_ACK_BIT]) begin
                det_flag_d = 1'b0;
            end
        end
        if (wr_c) begin
            det_trip_d = reg_wdata[C_DET_TRIP_BIT];
            wrn_trip_d = reg_wdata[C_WRN_TRIP_BIT];
            if (reg_wdata[C_WARN_ACK_BIT]) begin
                warn_d = 1'b0;
            end
        end
        if (wr_p) begin
            clksel_d = reg_wdata[P_CLKSEL_BIT];
            per_ie_d = reg_wdata[P_IRQ_EN_BIT];
            period_d = reg_wdata[P_PERIOD_LSB +: PERIOD_W];
            if (reg_wdata[P_ACK_BIT]) begin
                per_flag_d = 1'b0;
            end
        end
        if (reg_wr && reg_addr == OFS_IRQ_ENABLE) begin
            irq_en_d = reg_wdata[IRQ_W-1:0];
        end
        if (reg_wr && reg_addr == OFS_IRQ_CLEAR) begin
            irq_st_d = irq_st_q & ~reg_wdata[IRQ_W-1:0];
        end
        if (other_reset) begin
            por_c_d = 1'b0;
            lvd_c_d = 1'b0;
        end
        // Hardware events
        if (det_event) begin
            det_flag_d            = 1'b1;
            irq_st_d[IRQ_DET_BIT] = 1'b1;
        end
        if (det_on && lvw_s) begin
            warn_d = 1'b1;
        end
        if (per_expire) begin
            per_flag_d            = 1'b1;
            irq_st_d[IRQ_PER_BIT] = 1'b1;
        end
        if (lvd_trip) begin
            lvd_c_d = 1'b1;
        end
        // While reset is held, flags of the running system are cleared
        if (hold_q) begin
            det_flag_d = 1'b0;
            warn_d     = 1'b0;
            per_flag_d = 1'b0;
            irq_st_d   = '0;
        end
    end

    // Register the control and status bits
    always_ff @(posedge sys_clk) begin
        if (rst_all) begin
            det_en_q   <= RST_DET_EN;
            stop_en_q  <= RST_STOP_EN;
            rst_en_q   <= RST_RST_EN;
            det_ie_q   <= RST_IRQ_EN;
            det_trip_q <= RST_DET_TRIP;
            wrn_trip_q <= RST_WRN_TRIP;
            clksel_q   <= RST_CLKSEL;
            per_ie_q   <= RST_PER_IRQ_EN;
            period_q   <= RST_PERIOD;
            irq_en_q   <= RST_IRQ_ENABLE;
            det_flag_q <= 1'b0;
            warn_q     <= 1'b0;
            per_flag_q <= 1'b0;
            irq_st_q   <= '0;
            por_c_q    <= 1'b1;
            lvd_c_q    <= 1'b1;
        end else if (clk_en) begin
            det_en_q   <= det_en_d;
            stop_en_q  <= stop_en_d;
            rst_en_q   <= rst_en_d;
            det_ie_q   <= det_ie_d;
            det_trip_q <= det_trip_d;
            wrn_trip_q <= wrn_trip_d;
            clksel_q   <= clksel_d;
            per_ie_q   <= per_ie_d;
            period_q   <= period_d;
            irq_en_q   <= irq_en_d;
            det_flag_q <= det_flag_d;
            warn_q     <= warn_d;
            per_flag_q <= per_flag_d;
            irq_st_q   <= irq_st_d;
            por_c_q    <= por_c_d;
            lvd_c_q    <= lvd_c_d;
        end
    end

    // ********************************************************************
    // Read port
    // ********************************************************************

    // Read data is registered; write-only bits and unmapped offsets read 0
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_PWR_CTL_A: begin
                    rdata_d[A_FLAG_BIT]    = det_flag_q;
                    rdata_d[A_IRQ_EN_BIT]  = det_ie_q;
                    rdata_d[A_RST_EN_BIT]  = rst_en_q;
                    rdata_d[A_STOP_EN_BIT] = stop_en_q;
                    rdata_d[A_DET_EN_BIT]  = det_en_q;
                end
                OFS_PWR_CTL_C: begin
                    rdata_d[C_WARN_BIT]     = warn_q;
                    rdata_d[C_DET_TRIP_BIT] = det_trip_q;
                    rdata_d[C_WRN_TRIP_BIT] = wrn_trip_q;
                end
                OFS_RESET_CAUSE: begin
                    rdata_d[RC_POR_BIT] = por_c_q;
                    rdata_d[RC_LVD_BIT] = lvd_c_q;
                end
                OFS_PERIODIC_CTL: begin
                    rdata_d[P_FLAG_BIT]   = per_flag_q;
                    rdata_d[P_CLKSEL_BIT] = clksel_q;
                    rdata_d[P_IRQ_EN_BIT] = per_ie_q;
                    rdata_d[P_PERIOD_LSB +: PERIOD_W] = period_q;
                end
                OFS_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_st_q;
                OFS_IRQ_ENABLE: rdata_d[IRQ_W-1:0] = irq_en_q;
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    // ********************************************************************
    // Reset hold and stop mode controller
    // ********************************************************************

    // Hold reset from power-on or detector trip until the supply recovers
    always_comb begin
        hold_d = hold_q;
        if (por_s || lvd_trip) begin
            hold_d = 1'b1;
        end else if (!lvd_s) begin
            hold_d = 1'b0;
        end
    end

    // Stop entry, refusal of deep stops and wakeup
    always_comb begin
        state_d   = state_q;
        refused_d = 1'b0;
        unique case (state_q)
            ST_RUN: begin
                if (stop_req && !hold_q) begin
                    if (stop_mode_req == STOP_REQ_3) begin
                        state_d = ST_STOP3;
                    end else if (det_en_q && stop_en_q) begin
                        refused_d = 1'b1;
                    end else if (stop_mode_req == STOP_REQ_2) begin
                        state_d = ST_STOP2;
                    end else if (stop_mode_req == STOP_REQ_1) begin
                        state_d = ST_STOP1;
                    end
                end
            end
            ST_STOP1, ST_STOP2, ST_STOP3: begin
                if (wake_s || hold_q || (per_expire && per_ie_q) ||
                    (det_event && state_q == ST_STOP3)) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    // Register hold, state and read data
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hold_q    <= 1'b1;
            state_q   <= ST_RUN;
            refused_q <= 1'b0;
            rdata_q   <= 8'h00;
        end else if (clk_en) begin
            hold_q    <= hold_d;
            state_q   <= state_d;
            refused_q <= refused_d;
            rdata_q   <= rdata_d;
        end
    end

    // ********************************************************************
    // Periodic wakeup timer
    // ********************************************************************

    // External ticks are blocked in deep stop, internal ticks always pass
    assign per_tick = clksel_q ? (ext_tick & ~in_deep)
                               : int_tick;

    lvpw_period_timer u_timer (
        .sys_clk    (sys_clk),
        .reset      (rst_all),
        .clk_en     (clk_en),
        .clear      (hold_q),
        .tick       (per_tick),
        .period_sel (period_q),
        .expire     (per_expire)
    );

    // ********************************************************************
    // Outputs
    // ********************************************************************

    // Analog controls come from registers; reset also has a raw stop path
    assign detector_active   = det_on | hold_q;
    assign detect_trip_high  = det_trip_q;
    assign warning_trip_high = wrn_trip_q;
    assign sys_reset_out     = hold_q | por_det_raw |
                               (in_stop & det_on & rst_en_q & lvd_det_raw);
    assign irq = |(irq_st_q & irq_en_q & {per_ie_q, det_ie_q});
    assign reg_rdata    = rdata_q;
    assign stop_refused = refused_q;
    assign light_stop   = (state_q == ST_STOP3);
    assign deep_stop    = in_deep;

endmodule

// file: src/lvpw_pkg.sv
// Constants, register map and helpers for the low-voltage and wakeup control
package lvpw_pkg;

    // ********************************************************************
    // Register bus geometry
    // ********************************************************************
    localparam int         ADDR_W = 8;
    localparam int         DATA_W = 8;

    // ********************************************************************
    // Register offsets
    // ********************************************************************
    localparam logic [7:0] OFS_PWR_CTL_A    = 8'h00;
    localparam logic [7:0] OFS_PWR_CTL_C    = 8'h01;
    localparam logic [7:0] OFS_RESET_CAUSE  = 8'h02;
    localparam logic [7:0] OFS_PERIODIC_CTL = 8'h03;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h04;
    localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h05;
    localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h06;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int         A_FLAG_BIT     = 7;
    localparam int         A_ACK_BIT      = 6;
    localparam int         A_IRQ_EN_BIT   = 5;
    localparam int         A_RST_EN_BIT   = 4;
    localparam int         A_STOP_EN_BIT  = 3;
    localparam int         A_DET_EN_BIT   = 2;
    localparam int         C_WARN_BIT     = 7;
    localparam int         C_WARN_ACK_BIT = 6;
    localparam int         C_DET_TRIP_BIT = 5;
    localparam int         C_WRN_TRIP_BIT = 4;
    localparam int         RC_POR_BIT     = 7;
    localparam int         RC_LVD_BIT     = 1;
    localparam int         P_FLAG_BIT     = 7;
    localparam int         P_ACK_BIT      = 6;
    localparam int         P_CLKSEL_BIT   = 5;
    localparam int         P_IRQ_EN_BIT   = 4;
    localparam int         P_PERIOD_LSB   = 0;
    localparam int         PERIOD_W       = 3;
    localparam int         IRQ_W          = 2;
    localparam int         IRQ_DET_BIT    = 0;
    localparam int         IRQ_PER_BIT    = 1;

    // ********************************************************************
    // Values after reset
    // ********************************************************************
    localparam logic       RST_DET_EN     = 1'b1;
    localparam logic       RST_STOP_EN    = 1'b1;
    localparam logic       RST_RST_EN     = 1'b1;
    localparam logic       RST_IRQ_EN     = 1'b0;
    localparam logic       RST_DET_TRIP   = 1'b0;
    localparam logic       RST_WRN_TRIP   = 1'b0;
    localparam logic       RST_CLKSEL     = 1'b0;
    localparam logic       RST_PER_IRQ_EN = 1'b0;
    localparam logic [2:0] RST_PERIOD     = 3'h0;
    localparam logic [1:0] RST_IRQ_ENABLE = 2'h0;

    // ********************************************************************
    // Stop mode request codes and controller states
    // ********************************************************************
    localparam logic [1:0] STOP_REQ_1 = 2'h1;
    localparam logic [1:0] STOP_REQ_2 = 2'h2;
    localparam logic [1:0] STOP_REQ_3 = 2'h3;

    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_STOP1 = 4'b0010,
        ST_STOP2 = 4'b0100,
        ST_STOP3 = 4'b1000
    } lvpw_state_t;

    // ********************************************************************
    // Wakeup period table, in ticks of the selected timer clock
    // ********************************************************************
    localparam int         CNT_W = 10;

    function automatic logic [9:0] lvpw_period_len(input logic [2:0] sel);
        logic [9:0] len;
        len = 10'h000;
        case (sel)
            3'h1: len = 10'h007;
            3'h2: len = 10'h01f;
            3'h3: len = 10'h03f;
            3'h4: len = 10'h07f;
            3'h5: len = 10'h0ff;
            3'h6: len = 10'h1ff;
            3'h7: len = 10'h3ff;
            default: len = 10'h000;
        endcase
        return len;
    endfunction

endpackage

// file: src/lvpw_period_timer.sv
// Periodic wakeup counter that expires one tick after reaching the selected terminal value
`timescale 1ns/1ps
module lvpw_period_timer
    import lvpw_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire logic                  clear,
    input  wire logic                  tick,
    input  wire logic [PERIOD_W-1:0]   period_sel,
    output logic                       expire
);

    // ********************************************************************
    // Tick counter
    // ********************************************************************
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             expire_q;
    logic             expire_d;

    // Count ticks, wrap on the terminal value, idle while period is zero
    always_comb begin
        count_d  = count_q;
        expire_d = 1'b0;
        if (clear || period_sel == 3'h0) begin
            count_d = '0;
        end else if (tick) begin
            if (count_q >= lvpw_period_len(period_sel)) begin
                count_d  = '0;
                expire_d = 1'b1;
            end else begin
                count_d = count_q + 10'h001;
            end
        end
    end

    // Register the counter and the expiry pulse
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_q  <= '0;
            expire_q <= 1'b0;
        end else if (clk_en) begin
            count_q  <= count_d;
            expire_q <= expire_d;
        end
    end

    assign expire = expire_q;

endmodule

// file: tb/lvpw_ctl_checker.sv
// Port assertions for the low-voltage and wakeup control block
`timescale 1ns/1ps
module lvpw_ctl_checker
    import lvpw_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       por_det_raw,
    input wire logic       stop_req,
    input wire logic [1:0] stop_mode_req,
    input wire logic       stop_refused,
    input wire logic       light_stop,
    input wire logic       deep_stop,
    input wire logic       detector_active,
    input wire logic       sys_reset_out,
    input wire logic       irq
);
    // All checks run on the bus clock, idle during reset
    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    AST_POR_HOLD: assert property (por_det_raw |-> sys_reset_out)
        else $error("reset not held while supply below power-on level");
    AST_REL_HOLD: assert property ($fell(reset) |-> sys_reset_out)
        else $error("reset not held just after release");
    AST_RST_IRQ: assert property ($fell(reset) |-> !irq)
        else $error("interrupt request right after reset");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    AST_REF_SRC: assert property (stop_refused |->
        ($past(stop_req) || $past(stop_req, 2))
        && $past(stop_mode_req) != STOP_REQ_3)
        else $error("refusal without a deep stop request");
    AST_REF_RUN: assert property (stop_refused |-> !deep_stop && !light_stop)
        else $error("refused request still entered stop");
    AST_LIGHT_SRC: assert property ($rose(light_stop) |->
        ($past(stop_req) || $past(stop_req, 2))
        && $past(stop_mode_req) == STOP_REQ_3)
        else $error("light stop without its request");
    AST_DEEP_SRC: assert property ($rose(deep_stop) |->
        ($past(stop_req) || $past(stop_req, 2))
        && $past(stop_mode_req) != STOP_REQ_3)
        else $error("deep stop without its request");
    AST_DEEP_OFF: assert property (deep_stop && !sys_reset_out |-> !detector_active)
        else $error("detector powered in deep stop");
    AST_MODE_EXCL: assert property (!(light_stop && deep_stop))
        else $error("light and deep stop at once");
endmodule

// file: tb/lvpw_ctl_tb_top.sv
// Self-checking bench for the low-voltage and wakeup control block
`timescale 1ns/1ps
module lvpw_ctl_tb_top;
    import lvpw_pkg::*;
    logic        sys_clk, reset, rd, wr, por, lvd, supply_warning_flag, k1, xo, wk, orst;
    logic        sreq, refu, lst, dst, dact, dth, wth, srst, irq;
    logic [1:0]  smode;
    logic [7:0]  addr, wdat, rdat;
    logic [4:0]  tk;
    logic [15:0] rnd;
    int          error_cnt, cmp_count, tst;
    lvpw_ctl DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
        .reg_addr(addr), .reg_wdata(wdat), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdat), .por_det_raw(por), .lvd_det_raw(lvd),
        .lvw_det_raw(supply_warning_flag), .int_clk_1k(k1), .ext_osc_clk(xo),
        .wake_pin(wk), .other_reset(orst), .stop_req(sreq),
        .stop_mode_req(smode), .stop_refused(refu), .light_stop(lst),
        .deep_stop(dst), .detector_active(dact), .detect_trip_high(dth),
        .warning_trip_high(wth), .sys_reset_out(srst), .irq(irq));
    // Bus clock, 40 ns
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Fast timer clocks: internal period 8, external period 16 cycles
    always @(posedge sys_clk) begin
        tk <= tk + 5'h01;
        if (tk[1:0] == 2'h3) k1 <= ~k1;
        if (tk[2:0] == 3'h7) xo <= ~xo;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic pin(input string n, input logic e, input logic g);
        chk(n, {7'h0, e}, {7'h0, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr   <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk("rdata", e, rdat);
    endtask
    task automatic stp(input logic [1:0] m);
        @(posedge sys_clk);
        sreq  <= 1'b1;
        smode <= m;
        @(posedge sys_clk);
        sreq <= 1'b0;
        #1;
    endtask
    // Wake pin pulse returns to run
    task automatic wake();
        wk <= 1'b1;
        cyc(5);
        wk <= 1'b0;
        cyc(2);
        chk("stop", 8'h00, {6'h0, lst, dst});
    endtask
    task automatic endt();
        tst++;
        $display("test %0d done", tst);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        {rd, wr, por, lvd, supply_warning_flag, k1, xo, wk, orst, sreq} = '0;
        {reset, smode, addr, wdat, tk} = {1'b1, 2'h3, 21'h0};
        {rnd, error_cnt, cmp_count, tst} = {16'hee34, 96'h0};
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        cyc(6);
        // Reset values and an unmapped read
        rdc(OFS_PWR_CTL_A, 8'h1c);
        rdc(OFS_PWR_CTL_C, 8'h00);
        rdc(OFS_RESET_CAUSE, 8'h82);
        rdc(OFS_PERIODIC_CTL, 8'h00);
        rdc(8'h07, 8'h00);
        pin("srst", 1'b0, srst);
        pin("dact", 1'b1, dact);
        endt();
        // Trip selects, random interrupt enables
        for (int i = 0; i < 4; i++) begin
            wrr(OFS_PWR_CTL_C, 8'(i << 4));
            cyc(1);
            pin("dth", 1'(i >> 1), dth);
            pin("wth", 1'(i), wth);
            rnd = lfsr(rnd);
            wrr(OFS_IRQ_ENABLE, rnd[7:0]);
            rdc(OFS_IRQ_ENABLE, rnd[7:0] & 8'h03);
        end
        wrr(OFS_PWR_CTL_C, 8'h00);
        endt();
        // Detector reset held while supply low
        orst <= 1'b1;
        cyc(1);
        orst <= 1'b0;
        rdc(OFS_RESET_CAUSE, 8'h00);
        lvd <= 1'b1;
        cyc(5);
        pin("srst", 1'b1, srst);
        lvd <= 1'b0;
        cyc(6);
        pin("srst", 1'b0, srst);
        rdc(OFS_RESET_CAUSE, 8'h02);
        rdc(OFS_PWR_CTL_A, 8'h1c);
        endt();
        // Power-on detect
        por <= 1'b1;
        #1;
        pin("srst", 1'b1, srst);
        cyc(3);
        por <= 1'b0;
        cyc(6);
        rdc(OFS_RESET_CAUSE, 8'h82);
        endt();
        // Interrupt mode: flag and request, no reset
        wrr(OFS_PWR_CTL_A, 8'h24);
        wrr(OFS_IRQ_ENABLE, 8'h01);
        lvd <= 1'b1;
        cyc(6);
        pin("srst", 1'b0, srst);
        pin("irq", 1'b1, irq);
        rdc(OFS_PWR_CTL_A, 8'ha4);
        rdc(OFS_IRQ_STATUS, 8'h01);
        lvd <= 1'b0;
        cyc(4);
        wrr(OFS_PWR_CTL_A, 8'h64);
        wrr(OFS_IRQ_CLEAR, 8'h01);
        cyc(1);
        pin("irq", 1'b0, irq);
        // Warning flag, sticky, no interrupt
        supply_warning_flag <= 1'b1;
        cyc(6);
        supply_warning_flag <= 1'b0;
        rdc(OFS_PWR_CTL_C, 8'h80);
        pin("irq", 1'b0, irq);
        wrr(OFS_PWR_CTL_C, 8'h40);
        rdc(OFS_PWR_CTL_C, 8'h00);
        endt();
        // Deep stops refused while detector kept in stop
        wrr(OFS_PWR_CTL_A, 8'h0c);
        for (int m = 1; m < 3; m++) begin
            stp(2'(m));
            pin("refused", 1'b1, refu);
            cyc(2);
            pin("deep", 1'b0, dst);
        end
        stp(STOP_REQ_3);
        cyc(2);
        pin("light", 1'b1, lst);
        pin("dact", 1'b1, dact);
        wake();
        // Deep stop: detector off, external ticks do not wake
        wrr(OFS_PWR_CTL_A, 8'h04);
        wrr(OFS_PERIODIC_CTL, 8'h31);
        stp(STOP_REQ_1);
        cyc(300);
        pin("deep", 1'b1, dst);
        pin("dact", 1'b0, dact);
        wake();
        endt();
        // Internal clock wakeup period, local enable, zero period
        wrr(OFS_PERIODIC_CTL, 8'h50);
        wrr(OFS_IRQ_CLEAR, 8'h03);
        wrr(OFS_PERIODIC_CTL, 8'h11);
        wrr(OFS_IRQ_ENABLE, 8'h02);
        for (int w = 0; w < 300 && irq !== 1'b1; w++) cyc(1);
        pin("irq", 1'b1, irq);
        rdc(OFS_PERIODIC_CTL, 8'h91);
        wrr(OFS_PERIODIC_CTL, 8'h41);
        wrr(OFS_IRQ_CLEAR, 8'h02);
        cyc(100);
        pin("irq", 1'b0, irq);
        wrr(OFS_PERIODIC_CTL, 8'h50);
        wrr(OFS_IRQ_CLEAR, 8'h02);
        cyc(200);
        rdc(OFS_PERIODIC_CTL, 8'h10);
        pin("irq", 1'b0, irq);
        endt();
        complete_run();
    end
endmodule
bind lvpw_ctl lvpw_ctl_checker u_chk (.sys_clk(sys_clk), .reset(reset),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por_det_raw(por_det_raw),
    .stop_req(stop_req), .stop_mode_req(stop_mode_req),
    .stop_refused(stop_refused), .light_stop(light_stop),
    .deep_stop(deep_stop), .detector_active(detector_active),
    .sys_reset_out(sys_reset_out), .irq(irq));
